// ### common/llsm_defines.svh
// Constants for the load latency sampling monitor: register addresses,
// field positions, reset values and data-source codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef LLSM_DEFINES_SVH
`define LLSM_DEFINES_SVH

// Register addresses on the model-specific register port.
`define LLSM_THRESH_ADDR 32'h0000_03f6
`define LLSM_EVTSEL0_ADDR 32'h0000_0186
`define LLSM_PMC0_ADDR 32'h0000_00c1

// Widths and counts.
`define LLSM_NUM_CNT 4
`define LLSM_CNT_W 48
`define LLSM_VA_W 48
`define LLSM_TAG_W 2
`define LLSM_SLOTS 4
`define LLSM_LAT_W 32
`define LLSM_THR_W 16

// Reset values.
`define LLSM_THRESH_RST 16'h0000
`define LLSM_EVTSEL_RST 32'h0000_0000
`define LLSM_CNT_RST 48'h0000_0000_0000

// Event-select field positions.
`define LLSM_ES_EVENT_LO 0
`define LLSM_ES_EVENT_HI 7
`define LLSM_ES_UMASK_LO 8
`define LLSM_ES_UMASK_HI 15
`define LLSM_ES_EN_BIT 22

// Event code and unit mask that select the latency-above-threshold event.
`define LLSM_LAT_EVENT 8'h0b
`define LLSM_LAT_UMASK 8'h10

// Data-source codes.
`define LLSM_SRC_UNKNOWN 4'h0
`define LLSM_SRC_L1_HIT 4'h1
`define LLSM_SRC_FILL_BUF 4'h2
`define LLSM_SRC_L2_HIT 4'h3
`define LLSM_SRC_LLC_NOSNOOP 4'h4
`define LLSM_SRC_LLC_SNP_CLEAN 4'h5
`define LLSM_SRC_LLC_SNP_MOD 4'h6
`define LLSM_SRC_NO_DETAILS 4'h7
`define LLSM_SRC_XPKG_CLEAN 4'h8
`define LLSM_SRC_XPKG_MOD 4'h9
`define LLSM_SRC_LDRAM_S 4'ha
`define LLSM_SRC_RDRAM_S 4'hb
`define LLSM_SRC_LDRAM_E 4'hc
`define LLSM_SRC_RDRAM_E 4'hd
`define LLSM_SRC_IO 4'he
`define LLSM_SRC_UNCACHE 4'hf

`endif

// ### common/llsm_pkg.sv
// Types shared by the load latency sampling monitor files.
// Assumes the constants header is on the include path.
`include "llsm_defines.svh"

package llsm_pkg;

    // A load starting execution, with its effective address.
    typedef struct packed {
        logic valid;
        logic [`LLSM_TAG_W-1:0] tag;
        logic [`LLSM_VA_W-1:0] vaddr;
    } llsm_exec_type;

    // Data delivered for a load, with the hierarchy's source code.
    typedef struct packed {
        logic valid;
        logic [`LLSM_TAG_W-1:0] tag;
        logic [3:0] src;
    } llsm_done_type;

    // One measured load, or one captured sample record.
    typedef struct packed {
        logic valid;
        logic [`LLSM_LAT_W-1:0] lat;
        logic [`LLSM_VA_W-1:0] vaddr;
        logic [15:0] src;
    } llsm_rec_type;

endpackage

// ### verilog/llsm_lat_tracker.sv
// Per-load latency timer for the load latency sampling monitor.
// Assumes each tag is reused only after its data has been delivered.
`timescale 1ns/1ps
`include "llsm_defines.svh"

module llsm_lat_tracker
    import llsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire llsm_exec_type exec_in,
    input wire llsm_done_type done_in,
    output llsm_rec_type rec
);

    logic [`LLSM_LAT_W-1:0] now_r;
    logic [`LLSM_LAT_W-1:0] now_nxt;
    logic [`LLSM_LAT_W-1:0] start_r [`LLSM_SLOTS];
    logic [`LLSM_LAT_W-1:0] start_nxt [`LLSM_SLOTS];
    logic [`LLSM_VA_W-1:0] va_r [`LLSM_SLOTS];
    logic [`LLSM_VA_W-1:0] va_nxt [`LLSM_SLOTS];
    llsm_rec_type rec_r;
    llsm_rec_type rec_nxt;

    // The free-running stamp wraps; subtraction modulo 2^32 stays correct.
    // The address is latched at execute, so a load that overwrites its
    // own base register still reports the address it really used.
    always_comb
    begin
        now_nxt = now_r + 32'h0000_0001;
        start_nxt = start_r;
        va_nxt = va_r;
        if (exec_in.valid)
        begin
            start_nxt[exec_in.tag] = now_r;
            va_nxt[exec_in.tag] = exec_in.vaddr;
        end
        rec_nxt.valid = done_in.valid;
        rec_nxt.lat = now_r - start_r[done_in.tag];
        rec_nxt.vaddr = va_r[done_in.tag];
        rec_nxt.src = {12'h000, done_in.src};
    end

    // Registers of the timer.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            now_r <= 32'h0000_0000;
            rec_r <= '0;
            for (int i = 0; i < `LLSM_SLOTS; i++)
            begin
                start_r[i] <= 32'h0000_0000;
                va_r[i] <= '0;
            end
        end
        else
        begin
            now_r <= now_nxt;
            start_r <= start_nxt;
            va_r <= va_nxt;
            rec_r <= rec_nxt;
        end
    end

    assign rec = rec_r;

endmodule

// ### verilog/llsm_monitor.sv
// Load latency sampling monitor: threshold register, four counters,
// sampling arm logic and the captured sample record.
// Assumes the core's load pipeline drives execute and delivery strobes,
// and that software reaches the registers through the register port.
`timescale 1ns/1ps
`include "llsm_defines.svh"


module llsm_monitor
    import llsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [31:0] msr_addr,
    input wire logic msr_wr,
    input wire logic msr_rd,
    input wire logic [63:0] msr_wdata,
    output logic [63:0] msr_rdata,
    output logic msr_ack,
    output logic msr_hit,
    input wire llsm_exec_type load_exec,
    input wire llsm_done_type load_done,
    output llsm_rec_type sample,
    output logic sample_armed,
    output logic [`LLSM_NUM_CNT*`LLSM_CNT_W-1:0] cnt_values,
    output logic perf_monitor_interrupt
);

    localparam logic [`LLSM_CNT_W-1:0] CNT_MAX = '1;

    llsm_rec_type meas;
    logic [`LLSM_THR_W-1:0] thresh_r;
    logic [`LLSM_THR_W-1:0] thresh_nxt;
    logic [31:0] evtsel_r [`LLSM_NUM_CNT];
    logic [`LLSM_CNT_W-1:0] cnt_r [`LLSM_NUM_CNT];
    logic [`LLSM_NUM_CNT-1:0] sel;
    logic [`LLSM_NUM_CNT-1:0] ovf;
    logic exceed;
    logic capture;
    logic armed_r;
    logic armed_nxt;
    llsm_rec_type sample_r;
    llsm_rec_type sample_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [63:0] rdata_r;
    logic [63:0] rdata_nxt;
    logic ack_r;
    logic hit_r;
    logic hit_nxt;

    // Execute-to-delivery timing lives in the tracker.
    llsm_lat_tracker u_tracker (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .exec_in(load_exec),
        .done_in(load_done),
        .rec(meas)
    );

    // Folds codes that the hierarchy must not report onto unknown miss.
    function automatic logic [3:0] llsm_src_map(input logic [3:0] raw);
        logic [3:0] code;
        code = raw;
        if (raw == `LLSM_SRC_XPKG_MOD || raw == `LLSM_SRC_NO_DETAILS)
        begin
            code = `LLSM_SRC_UNKNOWN;
        end
        return code;
    endfunction

    // Only one threshold exists; every counter shares it.
    assign exceed = meas.valid &&
        (meas.lat > {16'h0000, thresh_r});

    // Per-counter event selection and counting.
    for (genvar g = 0; g < `LLSM_NUM_CNT; g++)
    begin : g_cnt
        logic [`LLSM_CNT_W-1:0] cnt_nxt;
        logic [31:0] es_nxt;
        logic es_hit;
        logic cn_hit;

        assign es_hit = msr_addr == (`LLSM_EVTSEL0_ADDR + 32'(g));
        assign cn_hit = msr_addr == (`LLSM_PMC0_ADDR + 32'(g));
        assign sel[g] = evtsel_r[g][`LLSM_ES_EN_BIT] &&
            evtsel_r[g][`LLSM_ES_EVENT_HI:`LLSM_ES_EVENT_LO]
                == `LLSM_LAT_EVENT &&
            evtsel_r[g][`LLSM_ES_UMASK_HI:`LLSM_ES_UMASK_LO]
                == `LLSM_LAT_UMASK;
        assign ovf[g] = sel[g] && exceed && cnt_r[g] == CNT_MAX;
        assign cnt_values[g*`LLSM_CNT_W +: `LLSM_CNT_W] = cnt_r[g];

        // A software write to a counter wins over a count in that cycle.
        always_comb
        begin
            es_nxt = evtsel_r[g];
            cnt_nxt = cnt_r[g];
            if (msr_wr && es_hit)
            begin
                es_nxt = msr_wdata[31:0];
            end
            if (msr_wr && cn_hit)
            begin
                cnt_nxt = msr_wdata[`LLSM_CNT_W-1:0];
            end
            else if (sel[g] && exceed)
            begin
                cnt_nxt = cnt_r[g] + 48'h0000_0000_0001;
            end
        end

        // Counter and event-select registers.
        always_ff @(posedge ref_clk)
        begin
            if (sys_rst)
            begin
                evtsel_r[g] <= `LLSM_EVTSEL_RST;
                cnt_r[g] <= `LLSM_CNT_RST;
            end
            else
            begin
                evtsel_r[g] <= es_nxt;
                cnt_r[g] <= cnt_nxt;
            end
        end
    end

    // Capture needs a counter still on the event so a stale arm is inert.
    assign capture = armed_r && exceed && (|sel);

    // Arm, capture and interrupt. An overflow in the capture cycle re-arms,
    // so the newer overflow is never lost behind the older sample.
    always_comb
    begin
        armed_nxt = armed_r;
        sample_nxt = sample_r;
        sample_nxt.valid = 1'b0;
        irq_nxt = 1'b0;
        if (capture)
        begin
            armed_nxt = 1'b0;
            sample_nxt.valid = 1'b1;
            sample_nxt.lat = meas.lat;
            sample_nxt.vaddr = meas.vaddr;
            sample_nxt.src = {12'h000,
                llsm_src_map(meas.src[3:0])};
            irq_nxt = 1'b1;
        end
        if (|ovf)
        begin
            armed_nxt = 1'b1;
        end
    end

    // Threshold register and register-port read path.
    always_comb
    begin
        thresh_nxt = thresh_r;
        rdata_nxt = 64'h0000_0000_0000_0000;
        hit_nxt = 1'b0;
        if (msr_wr && msr_addr == `LLSM_THRESH_ADDR)
        begin
            thresh_nxt = msr_wdata[`LLSM_THR_W-1:0];
        end
        if (msr_addr == `LLSM_THRESH_ADDR)
        begin
            rdata_nxt = {48'h0000_0000_0000, thresh_r};
            hit_nxt = 1'b1;
        end
        for (int i = 0; i < `LLSM_NUM_CNT; i++)
        begin
            if (msr_addr == (`LLSM_EVTSEL0_ADDR + 32'(i)))
            begin
                rdata_nxt = {32'h0000_0000, evtsel_r[i]};
                hit_nxt = 1'b1;
            end
            if (msr_addr == (`LLSM_PMC0_ADDR + 32'(i)))
            begin
                rdata_nxt = {16'h0000, cnt_r[i]};
                hit_nxt = 1'b1;
            end
        end
        if (!msr_rd)
        begin
            rdata_nxt = rdata_r;
        end
        hit_nxt = hit_nxt && (msr_rd || msr_wr);
    end

    // Register stage for state, record and port answers.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            thresh_r <= `LLSM_THRESH_RST;
            armed_r <= 1'b0;
            sample_r <= '0;
            irq_r <= 1'b0;
            rdata_r <= 64'h0000_0000_0000_0000;
            ack_r <= 1'b0;
            hit_r <= 1'b0;
        end
        else
        begin
            thresh_r <= thresh_nxt;
            armed_r <= armed_nxt;
            sample_r <= sample_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= msr_rd || msr_wr;
            hit_r <= hit_nxt;
        end
    end

    assign sample = sample_r;
    assign sample_armed = armed_r;
    assign perf_monitor_interrupt = irq_r;
    assign msr_rdata = rdata_r;
    assign msr_ack = ack_r;
    assign msr_hit = hit_r;

    // Checks. They watch internal state as well as the ports, so a
    // broken arm, count or capture path fails in the cycle in which it
    // goes wrong rather than many loads later.
    a_irq_with_record: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        perf_monitor_interrupt |-> sample_r.valid)
        else $error("interrupt without a fresh sample record");
    a_capture_disarms: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        capture && !(|ovf) |=> !armed_r)
        else $error("sampling stayed armed after a capture");
    a_overflow_arms: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (|ovf) |=> armed_r)
        else $error("overflow did not arm sampling");
    a_count_above_only: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        sel[0] && meas.valid && !exceed && !msr_wr
        |=> cnt_r[0] == $past(cnt_r[0]))
        else $error("counter moved on a load not above threshold");
    a_count_step: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        sel[0] && exceed && !msr_wr
        |=> cnt_r[0] == $past(cnt_r[0]) + 48'h0000_0000_0001)
        else $error("counter did not step by one");
    a_unselected_holds: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !sel[0] && !msr_wr |=> $stable(cnt_r[0]))
        else $error("counter moved while not on the latency event");
    a_sample_latency: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        capture |=> sample_r.lat == $past(meas.lat)
        && sample_r.lat > {16'h0000, $past(thresh_r)})
        else $error("sample latency wrong");
    a_sample_address: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        capture |=> sample_r.vaddr == $past(meas.vaddr))
        else $error("sample address wrong");
    a_src_low_bits: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        sample_r.valid |-> sample_r.src[15:4] == 12'h000
        && sample_r.src[3:0] != `LLSM_SRC_XPKG_MOD)
        else $error("source field malformed");
    a_unarmed_no_sample: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !armed_r |=> !sample_r.valid)
        else $error("sample written while disarmed");
    a_latency_elapsed: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        load_exec.valid ##1 !load_exec.valid ##1
        (load_done.valid && load_done.tag == $past(load_exec.tag, 2))
        |=> meas.lat == 32'h0000_0002)
        else $error("latency count wrong");
    a_threshold_write: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        msr_wr && msr_addr == `LLSM_THRESH_ADDR
        |=> thresh_r == $past(msr_wdata[15:0]))
        else $error("threshold register not written");

    // Scenarios that the bench is expected to reach; c_rearm, a capture in an overflow cycle, is never driven by the bench.
    c_overflow: cover property (@(posedge ref_clk) disable iff (sys_rst)
        |ovf);
    c_sample: cover property (@(posedge ref_clk) disable iff (sys_rst)
        perf_monitor_interrupt);
    c_rearm: cover property (@(posedge ref_clk) disable iff (sys_rst)
        capture && (|ovf));
    c_exact_threshold: cover property (@(posedge ref_clk)
        disable iff (sys_rst) meas.valid
        && meas.lat == {16'h0000, thresh_r});
    c_folded_source: cover property (@(posedge ref_clk) disable iff (sys_rst)
        capture && meas.src[3:0] == `LLSM_SRC_XPKG_MOD);

endmodule

// ### tb/llsm_load_model.sv
// Behavioural model of the core load pipeline feeding the monitor.
// Assumes one load in flight at a time and a latency of at least two.
`timescale 1ns/1ps
`include "llsm_defines.svh"

module llsm_load_model
    import llsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic req,
    input wire logic [`LLSM_TAG_W-1:0] req_tag,
    input wire logic [`LLSM_VA_W-1:0] req_va,
    input wire logic [15:0] req_lat,
    input wire logic [3:0] req_src,
    output llsm_exec_type load_exec,
    output llsm_done_type load_done,
    output logic busy
);
    logic [15:0] cnt_r;
    logic [`LLSM_TAG_W-1:0] tag_r;
    logic [3:0] src_r;

    // Idle address and source fields toggle every cycle, so a late latch
    // of either picks up garbage instead of a lucky stale value.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            load_exec <= '0;
            load_done <= '0;
            busy <= 1'b0;
            cnt_r <= 16'h0000;
        end
        else if (req)
        begin
            load_exec <= {1'b1, req_tag, req_va};
            tag_r <= req_tag;
            src_r <= req_src;
            cnt_r <= req_lat;
            busy <= 1'b1;
        end
        else
        begin
            load_exec.valid <= 1'b0;
            load_exec.vaddr <= ~load_exec.vaddr;
            if (cnt_r != 16'h0000)
                cnt_r <= cnt_r - 16'h0001;
            if (cnt_r == 16'h0001)
            begin
                load_done <= {1'b1, tag_r, src_r};
                busy <= 1'b0;
            end
            else
            begin
                load_done.valid <= 1'b0;
                load_done.src <= ~load_done.src;
            end
        end
    end
endmodule

// ### tb/llsm_monitor_tb.sv
// Self-checking bench for the load latency sampling monitor.
// Assumes the monitor and the load model are compiled before it.
`timescale 1ns/1ps
`include "llsm_defines.svh"

module llsm_monitor_tb
    import llsm_pkg::*;
();
    logic ref_clk = 1'b0;
    logic sys_rst, msr_wr, msr_rd, msr_ack, msr_hit, h, req, busy;
    logic sample_armed, perf_monitor_interrupt;
    logic [31:0] msr_addr;
    logic [63:0] msr_wdata, msr_rdata, q;
    logic [191:0] cnt_values;
    logic [15:0] req_lat;
    logic [3:0] req_src;
    logic [1:0] req_tag;
    logic [47:0] req_va;
    llsm_exec_type load_exec;
    llsm_done_type load_done;
    llsm_rec_type sample;
    int n_fail = 0, cmp_count = 0, n_smp = 0;
    // Rows: source code sent, then the 16-bit source field expected.
    logic [19:0] rows [16] = '{20'h0_0000, 20'h1_0001, 20'h2_0002,
        20'h3_0003, 20'h4_0004, 20'h5_0005, 20'h6_0006, 20'h7_0000,
        20'h8_0008, 20'h9_0000, 20'ha_000a, 20'hb_000b, 20'hc_000c,
        20'hd_000d, 20'he_000e, 20'hf_000f};

    llsm_monitor i_llsm_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .msr_addr(msr_addr), .msr_wr(msr_wr), .msr_rd(msr_rd),
        .msr_wdata(msr_wdata), .msr_rdata(msr_rdata), .msr_ack(msr_ack),
        .msr_hit(msr_hit), .load_exec(load_exec), .load_done(load_done),
        .sample(sample), .sample_armed(sample_armed),
        .cnt_values(cnt_values),
        .perf_monitor_interrupt(perf_monitor_interrupt));
    llsm_load_model i_llsm_load_model (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .req(req), .req_tag(req_tag), .req_va(req_va),
        .req_lat(req_lat), .req_src(req_src), .load_exec(load_exec),
        .load_done(load_done), .busy(busy));

    // A 25 ns period gives the 40 MHz core clock.
    always #12.5 ref_clk = ~ref_clk;

    task automatic end_sim();
        $display("Counts: %0d compared, %0d bad", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string nm, input logic [63:0] e,
        input logic [63:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // One register access; strobe is a single-cycle pulse, answer next.
    task automatic msr_op(input logic wr, input logic [31:0] a,
        input logic [63:0] d);
        int i;
        @(posedge ref_clk);
        msr_addr <= a;
        msr_wdata <= d;
        msr_wr <= wr;
        msr_rd <= !wr;
        @(posedge ref_clk);
        msr_wr <= 1'b0;
        msr_rd <= 1'b0;
        msr_addr <= ~a;
        msr_wdata <= ~d;
        for (i = 0; i < 4; i++)
        begin
            #1;
            if (msr_ack === 1'b1)
                break;
            @(posedge ref_clk);
        end
        if (i == 4)
        begin
            n_fail++;
            end_sim();
        end
        q = msr_rdata;
        h = msr_hit;
    endtask

    task automatic reg_chk(input logic [31:0] a, input logic [63:0] d,
        input logic [63:0] e, input logic eh);
        msr_op(1'b1, a, d);
        check("wr_hit", 64'(eh), 64'(h));
        msr_op(1'b0, a, 64'h0000_0000_0000_0000);
        check("rdata", e, q);
        check("rd_hit", 64'(eh), 64'(h));
    endtask

    // Issue one load and wait until its count and record have landed.
    task automatic run_load(input logic [15:0] l, input logic [3:0] s,
        input logic [47:0] v);
        int i;
        @(posedge ref_clk);
        req <= 1'b1;
        req_lat <= l;
        req_src <= s;
        req_va <= v;
        req_tag <= req_tag + 2'h1;
        @(posedge ref_clk);
        req <= 1'b0;
        for (i = 0; i < 300; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (busy === 1'b0)
                break;
        end
        if (i == 300)
        begin
            n_fail++;
            end_sim();
        end
        repeat (5) @(posedge ref_clk);
        #1;
    endtask

    // Every record written must come with the interrupt pulse; looked at
    // mid-cycle, where both registered pulses have settled.
    always @(negedge ref_clk)
    begin
        if (!sys_rst && (sample.valid || perf_monitor_interrupt))
        begin
            n_smp++;
            check("irq", 64'(sample.valid),
                64'(perf_monitor_interrupt));
        end
    end

    // Cuts a hang short at 1 ms, far beyond the length of a normal run.
    initial
    begin
        #1_000_000;
        n_fail++;
        end_sim();
    end

    // Main sequence: reset, registers, counting, capture, disarm.
    initial
    begin
        int i, s0;
        sys_rst = 1'b1;
        msr_wr = 1'b0;
        msr_rd = 1'b0;
        msr_addr = 32'h0000_0000;
        msr_wdata = 64'h0000_0000_0000_0000;
        req = 1'b0;
        req_lat = 16'h0002;
        req_src = 4'h0;
        req_tag = 2'h0;
        req_va = 48'h0000_0000_0000;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("armed_rst", 64'h0, 64'(sample_armed));
        check("cnt_rst", 64'h0, 64'(|cnt_values));
        msr_op(1'b0, `LLSM_THRESH_ADDR, 64'h0000_0000_0000_0000);
        check("thr_rst", 64'h0, q);
        $display("test reset done");
        reg_chk(`LLSM_THRESH_ADDR, 64'hffff_ffff_1234_abcd,
            64'h0000_0000_0000_abcd, 1'b1);
        reg_chk(32'h0000_03f7, 64'h0000_0000_0000_5555, 64'h0, 1'b0);
        reg_chk(`LLSM_PMC0_ADDR + 32'h3, '1,
            64'h0000_ffff_ffff_ffff, 1'b1);
        $display("test registers done");
        reg_chk(`LLSM_THRESH_ADDR, 64'h000a, 64'h000a, 1'b1);
        reg_chk(`LLSM_EVTSEL0_ADDR, 64'h0041_100b, 64'h0041_100b, 1'b1);
        reg_chk(`LLSM_PMC0_ADDR, 64'h0, 64'h0, 1'b1);
        run_load(16'h000a, 4'h1, 48'h0000_0000_1000);
        check("cnt_eq", 64'h0, 64'(cnt_values[47:0]));
        run_load(16'h000b, 4'h1, 48'h0000_0000_1000);
        check("cnt_gt", 64'h1, 64'(cnt_values[47:0]));
        reg_chk(`LLSM_EVTSEL0_ADDR, 64'h0040_010b, 64'h0040_010b, 1'b1);
        run_load(16'h0014, 4'h1, 48'h0000_0000_1000);
        check("cnt_umask", 64'h1, 64'(cnt_values[47:0]));
        reg_chk(`LLSM_EVTSEL0_ADDR, 64'h0041_100b, 64'h0041_100b, 1'b1);
        reg_chk(`LLSM_EVTSEL0_ADDR + 32'h3, 64'h0041_100b,
            64'h0041_100b, 1'b1);
        reg_chk(`LLSM_PMC0_ADDR + 32'h3, 64'h0, 64'h0, 1'b1);
        run_load(16'h000b, 4'h1, 48'h0000_0000_1000);
        check("cnt0", 64'h2, 64'(cnt_values[47:0]));
        check("cnt3", 64'h1, 64'(cnt_values[191:144]));
        run_load(16'h0002, 4'h1, 48'h0000_0000_1000);
        check("cnt_short", 64'h2, 64'(cnt_values[47:0]));
        $display("test counting done");
        for (i = 0; i < 16; i++)
        begin
            msr_op(1'b1, `LLSM_PMC0_ADDR, 64'h0000_ffff_ffff_ffff);
            s0 = n_smp;
            run_load(16'h000c, 4'h1, 48'h0000_0000_2000);
            check("wrap", 64'h0, 64'(cnt_values[47:0]));
            check("armed", 64'h1, 64'(sample_armed));
            check("no_smp", 64'(s0), 64'(n_smp));
            run_load(16'(11 + i), rows[i][19:16],
                {44'h123_4567_89ab, rows[i][19:16]});
            check("smp", 64'(s0 + 1), 64'(n_smp));
            check("lat", 64'(11 + i), 64'(sample.lat));
            check("va", 64'({44'h123_4567_89ab, rows[i][19:16]}),
                64'(sample.vaddr));
            check("src", 64'(rows[i][15:0]),
                64'(sample.src));
            check("disarm", 64'h0, 64'(sample_armed));
        end
        $display("test sources done");
        reg_chk(`LLSM_THRESH_ADDR, 64'h0020, 64'h0020, 1'b1);
        msr_op(1'b1, `LLSM_PMC0_ADDR, 64'h0000_ffff_ffff_ffff);
        s0 = n_smp;
        run_load(16'h0028, 4'h1, 48'h0000_0000_3000);
        run_load(16'h0020, 4'h2, 48'h0000_0000_4000);
        check("eq_thr", 64'(s0), 64'(n_smp));
        check("still", 64'h1, 64'(sample_armed));
        run_load(16'h0021, 4'hc, 48'hfedc_ba98_7654);
        check("lat33", 64'h21, 64'(sample.lat));
        check("va33", 64'hfedc_ba98_7654, 64'(sample.vaddr));
        run_load(16'h0032, 4'h3, 48'h0000_0000_5000);
        check("one_smp", 64'(s0 + 1), 64'(n_smp));
        check("lat_kept", 64'h21, 64'(sample.lat));
        $display("test disarm done");
        end_sim();
    end
endmodule
